/* core/drr_pkg.sv */
// package for the refresh request engine: parameter word offsets,
// field layout, reset values, routine states and carrier structs.
// assumes one system clock domain; pins arrive unsynchronised.
package drr_pkg;

   // ==========================================================
   // parameter memory map (byte offsets from the ram base)
   localparam logic [11:0] OFS_START_HI   = 12'h570;
   localparam logic [11:0] OFS_START_LO   = 12'h572;
   localparam logic [11:0] OFS_ROW_STEP   = 12'h574;
   localparam logic [11:0] OFS_ROW_TOTAL  = 12'h576;
   localparam logic [11:0] OFS_WORK_HI    = 12'h578;
   localparam logic [11:0] OFS_WORK_LO    = 12'h57A;
   localparam logic [11:0] OFS_CYC_LEFT   = 12'h57C;
   localparam logic [11:0] OFS_SPARE      = 12'h57E;
   localparam logic [11:0] OFS_BERR_CHAN  = 12'h67C;
   localparam logic [11:0] OFS_AREA_MASK  = 12'hFF0;

   // word index inside the eight-word area
   localparam logic [2:0]  IDX_START_HI   = 3'h0;
   localparam logic [2:0]  IDX_START_LO   = 3'h1;
   localparam logic [2:0]  IDX_ROW_STEP   = 3'h2;
   localparam logic [2:0]  IDX_ROW_TOTAL  = 3'h3;
   localparam logic [2:0]  IDX_WORK_HI    = 3'h4;
   localparam logic [2:0]  IDX_WORK_LO    = 3'h5;
   localparam logic [2:0]  IDX_CYC_LEFT   = 3'h6;

   // ==========================================================
   // high word layout: bit 15 zero, fc in 14:12, 11:8 zero, addr 7:0
   localparam int          FC_MSB         = 14;
   localparam int          FC_LSB         = 12;
   localparam logic [15:0] HI_WORD_MASK   = 16'h70FF;
   localparam logic [15:0] BERR_CHAN_VAL  = 16'h0001;
   localparam logic [1:0]  HOST_PHASE     = 2'h0;
   localparam logic [15:0] RDATA_RST      = 16'h0000;
   localparam logic [4:0]  PIN_IDLE       = 5'h1F;

   // ==========================================================
   // routine states
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0,
      S_RCNT  = 4'h1,
      S_RHI   = 4'h2,
      S_RLO   = 4'h3,
      S_RTOT  = 4'h4,
      S_RSTEP = 4'h5,
      S_BREQ  = 4'h6,
      S_BCYC  = 4'h7,
      S_BERR  = 4'h8,
      S_WHI   = 4'h9,
      S_WLO   = 4'hA,
      S_WCNT  = 4'hB
   } drr_state_t;

   // system bus outputs of one refresh read
   typedef struct packed {
      logic [23:0] addr;
      logic [2:0]  fc;
      logic        as_n;
      logic        rw;
      logic        uds_n;
      logic        lds_n;
   } drr_bus_t;

   // grants of the priority scheduler
   typedef struct packed {
      logic reset_g;
      logic berr_g;
      logic cmd_g;
      logic serial_g;
   } drr_grant_t;

endpackage

/* core/drr_engine.sv */
// refresh request engine: request pin edge capture, scheduler,
// parameter memory with host port, one byte read per request.
// assumes a bus arbiter on the same clock and pins needing sync.
`timescale 1ns/1ns

// ==========================================================
// three-stage synchroniser, level taken when stages two and three agree
module drr_sync #(
   parameter int          W       = 5,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // pins and agreed level
   input  wire logic [W-1:0] pin_in,
   output      logic [W-1:0] lvl_ff
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);

   // shift chain; only stage two reads stage one
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_ff  <= RST_VAL;
         s2_ff  <= RST_VAL;
         s3_ff  <= RST_VAL;
         lvl_ff <= RST_VAL;
      end else begin
         s1_ff  <= pin_in;
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         lvl_ff <= (agree & s3_ff) | (~agree & lvl_ff);
      end
   end
endmodule // drr_sync

// ==========================================================
// Behaviour
// - enabled falling pin edge starts refresh routine
// - one accepted request, exactly one read
// - parameters undefined at reset, readable always
// - high word: fc 14:12, address 7:0
// - low word gives lower sixteen address bits
// - add row step to pointer each cycle
// - after row total, reload pointer from start
// - working pointer words mirror start words
// - working count holds cycles before wrap
// - host and engine never share memory slot
// - reset first, bus error second, then refresh
// - byte read, odd lower strobe, even upper
// - bus error writes 0001 at 67C
// - no refresh starts while bus exception active
// - refresh beats serial service and commands
module drr_engine
   import drr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // request pin and enable bit of the system control register
   input  wire logic        refresh_request_pin,
   input  wire logic        ext_request_enable,
   // host port into parameter memory
   input  wire logic        hp_sel,
   input  wire logic        hp_wr,
   input  wire logic [11:0] hp_addr,
   input  wire logic [15:0] hp_wdata,
   output      logic [15:0] hp_rdata_ff,
   output      logic        hp_ack_ff,
   // other scheduler requests, same clock
   input  wire logic        cp_reset_req,
   input  wire logic        berr_service_req,
   input  wire logic        cmd_service_req,
   input  wire logic        serial_service_req,
   output      drr_grant_t  sched_grant,
   // system bus, arbiter on same clock, strobes from pins
   output      logic        bus_req_ff,
   input  wire logic        bus_grant,
   output      drr_bus_t    bus_ff,
   input  wire logic        dtack_n,
   input  wire logic        berr_n,
   input  wire logic        halt_n,
   input  wire logic        bus_reset_n,
   // bus-error channel number write
   output      logic        berr_chan_wr_ff,
   output      logic [11:0] berr_chan_addr,
   output      logic [15:0] berr_chan_data
);
   // ==========================================================
   // declarations
   logic [15:0] mem [0:7];
   logic [4:0]  pin_lvl;
   logic        req_prev_ff;
   logic        pend_ff;
   logic [1:0]  phase_ff;
   drr_state_t  state_ff;
   drr_state_t  nxt_state;
   logic [15:0] ptr_hi_ff;
   logic [15:0] ptr_lo_ff;
   logic [15:0] cnt_ff;
   logic [15:0] step_ff;
   logic        reload_ff;

   // ==========================================================
   // pin synchronisers
   drr_sync #(.W(5), .RST_VAL(PIN_IDLE)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  ({refresh_request_pin, dtack_n, berr_n, halt_n, bus_reset_n}),
      .lvl_ff  (pin_lvl)
   );

   wire req_lvl     = pin_lvl[4];
   wire dtack_seen  = ~pin_lvl[3];
   wire berr_seen   = ~pin_lvl[2];
   wire bus_exc     = ~pin_lvl[2] | ~pin_lvl[1] | ~pin_lvl[0];

   // ==========================================================
   // request edge and scheduler decode
   // edge counts only when enabled
   wire fall_edge   = req_prev_ff & ~req_lvl & ext_request_enable;
   wire idle        = (state_ff == S_IDLE);
   wire hi_pri      = cp_reset_req | berr_service_req;
   wire take        = idle & pend_ff & ~hi_pri & ~bus_exc;

   assign sched_grant.reset_g  = idle & cp_reset_req;
   assign sched_grant.berr_g   = idle & ~cp_reset_req & berr_service_req;
   assign sched_grant.cmd_g    = idle & ~hi_pri & ~pend_ff & cmd_service_req;
   assign sched_grant.serial_g = idle & ~hi_pri & ~pend_ff & ~cmd_service_req & serial_service_req;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         req_prev_ff <= 1'b1;
         pend_ff     <= 1'b0;
      end else begin
         req_prev_ff <= req_lvl;
         pend_ff     <= fall_edge | (pend_ff & ~take);
      end
   end

   // ==========================================================
   // memory slotting: one phase in four for the host
   // host slot excludes engine
   wire host_slot   = (phase_ff == HOST_PHASE);
   wire in_area     = ((hp_addr & OFS_AREA_MASK) == OFS_START_HI);
   wire [2:0] h_idx = hp_addr[3:1];
   wire host_take   = hp_sel & host_slot & ~hp_ack_ff;
   wire mem_state   = (state_ff inside {S_RCNT, S_RHI, S_RLO, S_RTOT, S_RSTEP, S_WHI, S_WLO, S_WCNT});
   // engine waits one clock at most on a host slot
   wire ctrl_go     = mem_state & ~host_slot;

   // engine word index per state
   logic [2:0] c_idx;
   always_comb begin
      case (state_ff)
         S_RCNT:  c_idx = IDX_CYC_LEFT;
         S_RHI:   c_idx = reload_ff ? IDX_START_HI : IDX_WORK_HI;
         S_RLO:   c_idx = reload_ff ? IDX_START_LO : IDX_WORK_LO;
         S_RTOT:  c_idx = IDX_ROW_TOTAL;
         S_RSTEP: c_idx = IDX_ROW_STEP;
         S_WHI:   c_idx = IDX_WORK_HI;
         S_WLO:   c_idx = IDX_WORK_LO;
         S_WCNT:  c_idx = IDX_CYC_LEFT;
         default: c_idx = IDX_CYC_LEFT;
      endcase
   end

   wire [15:0] c_rd   = mem[c_idx];
   wire        c_wr   = ctrl_go & (state_ff inside {S_WHI, S_WLO, S_WCNT});
   wire [15:0] c_wd   = (state_ff == S_WHI) ? (ptr_hi_ff & HI_WORD_MASK) :
                        (state_ff == S_WLO) ? ptr_lo_ff : cnt_ff;
   wire [15:0] h_wd   = (h_idx == IDX_START_HI) ? (hp_wdata & HI_WORD_MASK) : hp_wdata;
   wire        h_wr   = host_take & hp_wr & in_area;

   // no reset on the array, read any time
   always_ff @(posedge clk_sys) begin
      if (h_wr) begin
         mem[h_idx] <= h_wd;
      end else if (c_wr) begin
         mem[c_idx] <= c_wd;
      end
   end

   // host answer one clock after its slot; unmapped reads zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         phase_ff    <= 2'h0;
         hp_ack_ff   <= 1'b0;
         hp_rdata_ff <= RDATA_RST;
      end else begin
         phase_ff  <= phase_ff + 2'h1;
         hp_ack_ff <= host_take;
         if (host_take) begin
            hp_rdata_ff <= in_area ? mem[h_idx] : RDATA_RST;
         end
      end
   end

   // ==========================================================
   // routine sequencing
   wire bus_done = (state_ff == S_BCYC) & (dtack_seen | berr_seen);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE:  if (take) nxt_state = S_RCNT;
         S_RCNT:  if (ctrl_go) nxt_state = S_RHI;
         S_RHI:   if (ctrl_go) nxt_state = S_RLO;
         S_RLO:   if (ctrl_go) nxt_state = reload_ff ? S_RTOT : S_RSTEP;
         S_RTOT:  if (ctrl_go) nxt_state = S_RSTEP;
         S_RSTEP: if (ctrl_go) nxt_state = S_BREQ;
         S_BREQ:  if (bus_grant) nxt_state = S_BCYC;
         S_BCYC:  if (bus_done) nxt_state = berr_seen ? S_BERR : S_WHI;
         S_BERR:  nxt_state = S_WHI;
         S_WHI:   if (ctrl_go) nxt_state = S_WLO;
         S_WLO:   if (ctrl_go) nxt_state = S_WCNT;
         S_WCNT:  if (ctrl_go) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // pointer plus row step, carry into high byte
   wire [23:0] ptr_sum = {ptr_hi_ff[7:0], ptr_lo_ff} + {8'h00, step_ff};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // working copies of the parameters
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ptr_hi_ff <= 16'h0000;
         ptr_lo_ff <= 16'h0000;
         cnt_ff    <= 16'h0000;
         step_ff   <= 16'h0000;
         reload_ff <= 1'b0;
      end else begin
         if (ctrl_go && state_ff == S_RCNT) begin
            cnt_ff    <= c_rd;
            reload_ff <= (c_rd == 16'h0000);
         end
         if (ctrl_go && state_ff == S_RHI) begin
            ptr_hi_ff <= c_rd;
         end
         if (ctrl_go && state_ff == S_RLO) begin
            ptr_lo_ff <= c_rd;
         end
         if (ctrl_go && state_ff == S_RTOT) begin
            cnt_ff <= c_rd;
         end
         if (ctrl_go && state_ff == S_RSTEP) begin
            step_ff <= c_rd;
         end
         // advance after the read, error or not
         if (bus_done) begin
            ptr_hi_ff <= {ptr_hi_ff[15:8], ptr_sum[23:16]};
            ptr_lo_ff <= ptr_sum[15:0];
            cnt_ff    <= cnt_ff - 16'h0001;
         end
      end
   end

   // ==========================================================
   // bus cycle: one byte read, strobes held until dtack or error
   // a single cycle per routine
   wire bus_start = (state_ff == S_BREQ) & bus_grant;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus_req_ff <= 1'b0;
         bus_ff     <= '{addr: 24'h000000, fc: 3'h0, as_n: 1'b1, rw: 1'b1, uds_n: 1'b1, lds_n: 1'b1};
      end else begin
         bus_req_ff <= (nxt_state == S_BREQ);
         if (bus_start) begin
            // fc and upper address from high word
            bus_ff.addr  <= {ptr_hi_ff[7:0], ptr_lo_ff};
            bus_ff.fc    <= ptr_hi_ff[FC_MSB:FC_LSB];
            bus_ff.as_n  <= 1'b0;
            bus_ff.rw    <= 1'b1;
            bus_ff.uds_n <= ptr_lo_ff[0];
            bus_ff.lds_n <= ~ptr_lo_ff[0];
         end else if (bus_done) begin
            bus_ff.as_n  <= 1'b1;
            bus_ff.uds_n <= 1'b1;
            bus_ff.lds_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // bus error channel number write
   // error posts channel one
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         berr_chan_wr_ff <= 1'b0;
      end else begin
         berr_chan_wr_ff <= bus_done & berr_seen;
      end
   end

   assign berr_chan_addr = OFS_BERR_CHAN;
   assign berr_chan_data = BERR_CHAN_VAL; // same value as channel one receive

endmodule // drr_engine

/* dv/drr_dram_model.sv */
// dram bank behind the strobe pal: grants the bus, answers reads.
// assumes registered engine outputs; pins idle high by pull-ups.
`timescale 1ns/1ns
module drr_dram_model
   import drr_pkg::*;
(
   // clock, reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // engine bus
   input  wire logic       bus_req_ff,
   input  wire drr_bus_t   bus_ff,
   output      logic       bus_grant = 1'b0,
   output      logic       dtack_n = 1'b1,
   output      logic       berr_n = 1'b1,
   // bench knobs: answer delay, answer with bus error
   input  wire logic [3:0] wait_cyc,
   input  wire logic       fail_rd
);
   logic [3:0] cnt_ff;
   drr_bus_t   rd_q[$];
   // ==========
   // slow or prompt answer; released pins return to pull-up high
   always @(posedge clk_sys) begin
      bus_grant <= rst_n & (bus_req_ff | ~bus_ff.as_n);
      if (!rst_n || bus_ff.as_n) begin
         cnt_ff            <= 4'h0;
         {dtack_n, berr_n} <= 2'h3;
      end else if (cnt_ff <= wait_cyc) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff == wait_cyc) begin
            rd_q.push_back(bus_ff);
            {dtack_n, berr_n} <= {fail_rd, ~fail_rd};
         end
      end
   end
endmodule // drr_dram_model

/* dv/drr_engine_assertions.sv */
// port assertions for the refresh engine: strobes, host pacing,
// scheduler order. assumes one clock and a bind onto drr_engine.
`timescale 1ns/1ns
module drr_engine_assertions
   import drr_pkg::*;
(
   // clock, reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // watched ports
   input wire logic        refresh_request_pin,
   input wire logic        ext_request_enable,
   input wire logic        hp_sel,
   input wire logic        hp_ack_ff,
   input wire logic        cp_reset_req,
   input wire logic        berr_service_req,
   input wire drr_grant_t  sched_grant,
   input wire logic        bus_req_ff,
   input wire drr_bus_t    bus_ff,
   input wire logic        berr_chan_wr_ff,
   input wire logic [11:0] berr_chan_addr,
   input wire logic [15:0] berr_chan_data
);
   default clocking dcb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [15:0] n_req_ff, n_rd_ff;
   logic        pin_d_ff, as_d_ff;
   // ==========
   // enabled pin falls against started reads; merges only lower reads
   always_ff @(posedge clk_sys) begin
      pin_d_ff <= refresh_request_pin;
      as_d_ff  <= bus_ff.as_n;
      n_req_ff <= !rst_n ? 16'h0000 : n_req_ff + 16'(pin_d_ff & ~refresh_request_pin & ext_request_enable);
      n_rd_ff  <= !rst_n ? 16'h0000 : n_rd_ff + 16'(as_d_ff & ~bus_ff.as_n);
   end
   // ==========
   // bus cycle shape
   a_one_read_each: assert property (n_rd_ff <= n_req_ff)
      else $error("more bus reads than requests");
   a_strobe_hold: assert property ($fell(bus_ff.as_n) |-> !bus_ff.as_n [*3])
      else $error("address strobe dropped early");
   a_req_then_cycle: assert property ($fell(bus_ff.as_n) |-> $past(bus_req_ff))
      else $error("bus cycle started without a request");
   a_byte_read: assert property (!bus_ff.as_n |-> bus_ff.rw && (bus_ff.uds_n || bus_ff.lds_n))
      else $error("not a byte read");
   a_lane_parity: assert property (!bus_ff.uds_n || !bus_ff.lds_n |-> bus_ff.lds_n == !bus_ff.addr[0])
      else $error("wrong data strobe for address");
   a_berr_word: assert property (berr_chan_wr_ff |-> $rose(bus_ff.as_n)
      && berr_chan_addr == 12'h67C && berr_chan_data == 16'h0001)
      else $error("bad bus error channel write");
   // ==========
   // host slot and scheduler order
   a_ack_window: assert property ($rose(hp_sel) |-> ##[1:4] hp_ack_ff)
      else $error("host access waited too long");
   a_reset_first: assert property (sched_grant.berr_g || sched_grant.cmd_g || sched_grant.serial_g |-> !cp_reset_req)
      else $error("grant given over reset");
   a_berr_second: assert property (sched_grant.cmd_g || sched_grant.serial_g |-> !berr_service_req)
      else $error("grant given over bus error");
   c_bus_cycle: cover property ($fell(bus_ff.as_n));
   c_berr_write: cover property (berr_chan_wr_ff);
   c_berr_grant: cover property (sched_grant.berr_g);
endmodule // drr_engine_assertions

bind drr_engine drr_engine_assertions u_chk (.clk_sys, .rst_n, .refresh_request_pin, .ext_request_enable,
   .hp_sel, .hp_ack_ff, .cp_reset_req, .berr_service_req, .sched_grant, .bus_req_ff, .bus_ff, .berr_chan_wr_ff,
   .berr_chan_addr, .berr_chan_data);

/* dv/drr_engine_tb_top.sv */
// self-checking bench for the refresh engine with a dram model.
// assumes the checker binds itself from its own file.
`timescale 1ns/1ns
module drr_engine_tb_top
   import drr_pkg::*;
;
   // ==========
   // stimulus and observed signals
   logic        clk_sys = 1'b0, rst_n = 1'b0, hp_sel = 1'b0, hp_wr = 1'b0, fail_rd = 1'b0;
   logic        refresh_request_pin = 1'b1, ext_request_enable = 1'b0, halt_n = 1'b1, bus_reset_n = 1'b1;
   logic        cp_reset_req = 1'b0, berr_service_req = 1'b0, cmd_service_req = 1'b0, serial_service_req = 1'b0;
   logic [11:0] hp_addr = 12'h000, berr_chan_addr;
   logic [15:0] hp_wdata = 16'h0000, hp_rdata_ff, rd, d, s_hi, s_lo, step, tot, left, berr_chan_data;
   logic [3:0]  wait_cyc = 4'h1;
   logic [23:0] ptr;
   logic        hp_ack_ff, bus_req_ff, bus_grant, dtack_n, berr_n, berr_chan_wr_ff;
   drr_grant_t  sched_grant;
   drr_bus_t    bus_ff;
   int          n_mismatch = 0, tests_run = 0, n_berr = 0;

   always #20 clk_sys = ~clk_sys;
   drr_engine dut (.clk_sys, .rst_n, .refresh_request_pin, .ext_request_enable, .hp_sel, .hp_wr, .hp_addr,
      .hp_wdata, .hp_rdata_ff, .hp_ack_ff, .cp_reset_req, .berr_service_req, .cmd_service_req,
      .serial_service_req, .sched_grant, .bus_req_ff, .bus_grant, .bus_ff, .dtack_n, .berr_n, .halt_n,
      .bus_reset_n, .berr_chan_wr_ff, .berr_chan_addr, .berr_chan_data);
   drr_dram_model mdl (.clk_sys, .rst_n, .bus_req_ff, .bus_ff, .bus_grant, .dtack_n, .berr_n, .wait_cyc,
      .fail_rd);
   // bus-error channel writes seen
   always @(negedge clk_sys) if (berr_chan_wr_ff === 1'b1) n_berr++;

   // ==========
   // compare, host access, pin pulse
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // sel held until the ack cycle, then dropped in it
   task automatic host(input logic w, input logic [11:0] ad, input logic [15:0] wd);
      int k;
      @(negedge clk_sys);
      {hp_sel, hp_wr, hp_addr, hp_wdata} = {1'b1, w, ad, wd};
      for (k = 0; k < 8 && hp_ack_ff !== 1'b1; k++) @(negedge clk_sys);
      if (k == 8) chk(32'h0, 32'h1);
      rd     = hp_rdata_ff;
      hp_sel = 1'b0;
   endtask
   // low long enough for the three-stage sync
   task automatic pulse();
      @(negedge clk_sys) refresh_request_pin = 1'b0;
      repeat (6) @(negedge clk_sys);
      refresh_request_pin = 1'b1;
   endtask
   // host touches only the refresh words, never the descriptor area
   task automatic setup();
      s_hi = {1'b0, 3'($urandom_range(6, 0)), 4'h0, 8'($urandom)};
      s_lo = 16'($urandom);
      step = 16'($urandom) | 16'h0001;
      tot  = 16'h0003;
      left = 16'h0000;
      host(1'b1, OFS_START_HI, s_hi);
      host(1'b1, OFS_START_LO, s_lo);
      host(1'b1, OFS_ROW_STEP, step);
      host(1'b1, OFS_ROW_TOTAL, tot);
      host(1'b1, OFS_CYC_LEFT, 16'h0000);
      @(negedge clk_sys) ext_request_enable = 1'b1;
   endtask
   function automatic drr_bus_t exp_bus(input logic [23:0] p);
      exp_bus = '{addr: p, fc: s_hi[14:12], as_n: 1'b0, rw: 1'b1, uds_n: p[0], lds_n: ~p[0]};
   endfunction
   function automatic drr_grant_t exp_grant(input logic [3:0] r);
      exp_grant = r[3] ? 4'h8 : r[2] ? 4'h4 : r[1] ? 4'h2 : {3'h0, r[0]};
   endfunction
   // waits out the routine, so a second read would also be caught
   task automatic expect_rd(input logic ok);
      int k;
      for (k = 0; k < 300 && mdl.rd_q.size() == 0; k++) @(negedge clk_sys);
      repeat (40) @(negedge clk_sys);
      chk(32'(mdl.rd_q.size()), {31'h0, ok});
      if (ok && mdl.rd_q.size() != 0) begin
         if (left == 16'h0000) begin
            ptr  = {s_hi[7:0], s_lo};
            left = tot;
         end
         chk(32'(mdl.rd_q.pop_front()), 32'(exp_bus(ptr)));
         ptr  = ptr + {8'h00, step};
         left = left - 16'h0001;
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ==========
   // main sequence
   initial begin
      void'($urandom(32'h0153949e));
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      // readback, high word fields, unmapped reads zero
      for (int i = 0; i < 9; i++) begin
         d = 16'($urandom) & 16'hBFFF;
         host(1'b1, (i == 8) ? 12'h400 : OFS_START_HI + 12'(2 * i), d);
         host(1'b0, (i == 8) ? 12'h400 : OFS_START_HI + 12'(2 * i), 16'h0000);
         chk(32'(rd), (i == 8) ? 32'h0 : (i == 0) ? 32'(d & 16'h70FF) : 32'(d));
      end
      $display("test registers done");
      setup();
      for (int i = 0; i < 7; i++) begin
         wait_cyc = 4'($urandom_range(6, 1));
         pulse();
         expect_rd(1'b1);
      end
      host(1'b0, OFS_WORK_HI, 16'h0000);
      chk(32'(rd), {17'h0, s_hi[14:12], 4'h0, ptr[23:16]});
      host(1'b0, OFS_CYC_LEFT, 16'h0000);
      chk(32'(rd), {16'h0, left});
      $display("test refresh walk done");
      ext_request_enable = 1'b0;
      pulse();
      expect_rd(1'b0);
      {ext_request_enable, halt_n, cmd_service_req} = 3'b101;
      pulse();
      repeat (6) @(negedge clk_sys);
      chk(32'(sched_grant.cmd_g), 32'h0);
      expect_rd(1'b0);
      {halt_n, cmd_service_req} = 2'b10;
      expect_rd(1'b1);
      $display("test enable and halt done");
      d       = 16'(n_berr);
      fail_rd = 1'b1;
      pulse();
      expect_rd(1'b1);
      chk(32'(n_berr), 32'(d) + 32'h1);
      chk({4'h0, berr_chan_addr, berr_chan_data}, {4'h0, OFS_BERR_CHAN, 16'h0001});
      fail_rd = 1'b0;
      host(1'b0, OFS_WORK_LO, 16'h0000);
      chk(32'(rd), {16'h0, ptr[15:0]});
      $display("test bus error done");
      for (int i = 0; i < 16; i++) begin
         {cp_reset_req, berr_service_req, cmd_service_req, serial_service_req} = 4'(i);
         @(negedge clk_sys);
         chk(32'(sched_grant), 32'(exp_grant(4'(i))));
      end
      $display("test scheduler done");
      stop_test();
   end
   // watchdog: about seven times the expected run
   initial begin
      #400000;
      n_mismatch++;
      stop_test();
   end
endmodule // drr_engine_tb_top
